// ==== design/bca_cfg.svh ====
// timing, layout and code constants of the burst area encoder
`ifndef BCA_CFG_SVH
`define BCA_CFG_SVH

`define BCA_CLK_NS        8
// plain default bit period; set it for the writer's rotation speed
`define BCA_CHBIT_NS      512
`define BCA_CHBIT_CYC     (`BCA_CHBIT_NS / `BCA_CLK_NS)
`define BCA_HALF_CYC      9'(`BCA_CHBIT_CYC / 2)
`define BCA_N_MAX         4'hC
`define BCA_UNIT_BITS     5'h10
`define BCA_MARK_FIXED    8'h46
`define BCA_CODE_SYNC     4'h0
`define BCA_CODE_ECC      4'hD
`define BCA_CODE_POST_A   4'hE
`define BCA_CODE_POST_B   4'hF
`define BCA_PRE_BYTE      8'h00
`define BCA_POST_BYTE     8'h55
`define BCA_PRE_BYTES     3'h4
`define BCA_POST_LAST     3'h5
`define BCA_CRC_POLY      32'h80000011
`define BCA_GF_POLY       8'h1D
`define BCA_RS_G3         8'h0F
`define BCA_RS_G2         8'h36
`define BCA_RS_G1         8'h78
`define BCA_RS_G0         8'h40
`define BCA_FIFO_W        8
`define BCA_FIFO_D        8

`endif

// ==== design/bca_pkg.sv ====
// shared types of the burst area encoder
`default_nettype none
package bca_pkg;
    typedef enum logic [2:0] {
        BCA_IDLE,
        BCA_PRE,
        BCA_ROWS,
        BCA_POST,
        BCA_FIN
    } bca_seg_t;
endpackage
`default_nettype wire

// ==== design/bca_fifo.sv ====
// flop-based byte fifo with valid/ready on both sides
`default_nettype none
module bca_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } bca_fifo_state_t;

    bca_fifo_state_t st;
    bca_fifo_state_t next_st;
    logic            full;
    logic            empty;

    // extra pointer bit tells full from empty
    assign empty     = (st.wp == st.rp);
    assign full      = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = st.mem[st.rp[AW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wp[AW-1:0]] = in_data;
            next_st.wp                 = st.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // bca_fifo
`default_nettype wire

// ==== design/bca_encoder.sv ====
// burst area code framer, check generator and stripe modulator
`include "bca_cfg.svh"
`default_nettype none
module bca_encoder (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [3:0] n_rows,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            stripe,
    output logic            chan_bit,
    output logic            bit_strobe,
    output logic            busy,
    output logic            done,
    output logic            underrun
);
    typedef struct packed {
        bca_pkg::bca_seg_t   seg;
        logic [3:0]          n;
        logic [5:0]          row;
        logic [2:0]          col;
        logic [15:0]         shreg;
        logic [4:0]          bits_left;
        logic [8:0]          div;
        logic                phase;
        logic [31:0]         crc;
        logic [3:0][3:0][7:0] par;
        logic                stripe;
        logic                chan_bit;
        logic                bit_strobe;
        logic                done;
        logic                underrun;
    } bca_enc_state_t;

    bca_enc_state_t st;
    bca_enc_state_t next_st;
    logic           f_valid;
    logic           f_ready;
    logic [7:0]     f_data;

    bca_fifo #(
        .W (`BCA_FIFO_W),
        .D (`BCA_FIFO_D)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // phase encoding, msb first; inv selects the non-payload polarity
    function automatic logic [15:0] pe_byte(input logic [7:0] d, input logic inv);
        logic [15:0] r;
        r = '0;
        for (int k = 0; k < 8; k++) begin
            r[2*k +: 2] = (d[k] ^ inv) ? 2'b10 : 2'b01;
        end
        return r;
    endfunction

    function automatic logic [15:0] marker(input logic [3:0] code);
        logic [15:0] p;
        p = pe_byte({code, 4'h0}, 1'b1);
        return {`BCA_MARK_FIXED, p[15:8]};
    endfunction

    // msb-first division, so the first info msb carries the top bit number
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        logic        fb;
        r  = c;
        fb = 1'b0;
        for (int k = 7; k >= 0; k--) begin
            fb = r[31] ^ d[k];
            r  = {r[30:0], 1'b0} ^ (fb ? `BCA_CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] x;
        r = '0;
        x = a;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) begin
                r = r ^ x;
            end
            x = {x[6:0], 1'b0} ^ (x[7] ? `BCA_GF_POLY : 8'h00);
        end
        return r;
    endfunction

    // one message byte into a degree-4 remainder; p[3] is the x^3 term
    function automatic logic [3:0][7:0] rs_step(input logic [3:0][7:0] p, input logic [7:0] d);
        logic [3:0][7:0] q;
        logic [7:0]      fb;
        fb   = d ^ p[3];
        q[3] = p[2] ^ gf_mul(`BCA_RS_G3, fb);
        q[2] = p[1] ^ gf_mul(`BCA_RS_G2, fb);
        q[1] = p[0] ^ gf_mul(`BCA_RS_G1, fb);
        q[0] = gf_mul(`BCA_RS_G0, fb);
        return q;
    endfunction

    // d0 is the top byte of the remainder, d3 holds bit 0
    function automatic logic [7:0] edc_byte(input logic [31:0] c, input logic [1:0] j);
        logic [31:0] s;
        s = c << {j, 3'b000};
        return s[31:24];
    endfunction

    always_comb begin
        logic [15:0] unit;
        logic        ok;
        logic [1:0]  lane;
        logic [5:0]  four_n;
        logic [5:0]  ecc_row;
        logic [7:0]  d;
        unit    = '0;
        ok      = 1'b0;
        lane    = 2'(st.col - 3'd1);
        four_n  = {st.n, 2'b00};
        ecc_row = st.row - four_n;
        d       = '0;
        f_ready = 1'b0;
        next_st = st;
        next_st.bit_strobe = 1'b0;
        next_st.done       = 1'b0;
        if (st.seg == bca_pkg::BCA_IDLE) begin
            // a start with n out of range is ignored
            if (start && n_rows != 4'h0 && n_rows <= `BCA_N_MAX) begin
                next_st.seg       = bca_pkg::BCA_PRE;
                next_st.n         = n_rows;
                next_st.row       = '0;
                next_st.col       = '0;
                next_st.crc       = '0;
                next_st.par       = '0;
                next_st.bits_left = '0;
                next_st.underrun  = 1'b0;
            end
        end else if (st.bits_left == 5'h0) begin
            case (st.seg)
                bca_pkg::BCA_PRE: begin
                    ok   = 1'b1;
                    unit = (st.col == 3'd0) ? marker(`BCA_CODE_SYNC)
                                            : pe_byte(`BCA_PRE_BYTE, 1'b1);
                    if (st.col == `BCA_PRE_BYTES) begin
                        next_st.seg = bca_pkg::BCA_ROWS;
                        next_st.col = '0;
                    end else begin
                        next_st.col = st.col + 3'd1;
                    end
                end
                bca_pkg::BCA_ROWS: begin
                    if (st.col == 3'd0) begin
                        ok   = 1'b1;
                        unit = (st.row < four_n) ? marker(st.row[5:2] + 4'h1)
                                                 : marker(`BCA_CODE_ECC);
                    end else if (st.row + 6'd1 < four_n) begin
                        // info byte: shapes both checks on the way out
                        ok      = f_valid;
                        f_ready = f_valid;
                        unit    = pe_byte(f_data, 1'b0);
                        if (f_valid) begin
                            next_st.crc       = crc_byte(st.crc, f_data);
                            next_st.par[lane] = rs_step(st.par[lane], f_data);
                        end
                    end else if (st.row + 6'd1 == four_n) begin
                        ok                = 1'b1;
                        d                 = edc_byte(st.crc, lane);
                        unit              = pe_byte(d, 1'b0);
                        next_st.par[lane] = rs_step(st.par[lane], d);
                    end else begin
                        ok   = 1'b1;
                        unit = pe_byte(st.par[lane][2'd3 - ecc_row[1:0]], 1'b0);
                    end
                    if (ok) begin
                        if (st.col == 3'd4) begin
                            next_st.col = '0;
                            if (st.row == four_n + 6'd3) begin
                                next_st.seg = bca_pkg::BCA_POST;
                                next_st.row = '0;
                            end else begin
                                next_st.row = st.row + 6'd1;
                            end
                        end else begin
                            next_st.col = st.col + 3'd1;
                        end
                    end
                end
                bca_pkg::BCA_POST: begin
                    ok = 1'b1;
                    if (st.col == 3'd0) begin
                        unit = marker(`BCA_CODE_POST_A);
                    end else if (st.col == `BCA_POST_LAST) begin
                        unit = marker(`BCA_CODE_POST_B);
                    end else begin
                        unit = pe_byte(`BCA_POST_BYTE, 1'b1);
                    end
                    if (st.col == `BCA_POST_LAST) begin
                        next_st.seg = bca_pkg::BCA_FIN;
                    end else begin
                        next_st.col = st.col + 3'd1;
                    end
                end
                bca_pkg::BCA_FIN: begin
                    next_st.seg  = bca_pkg::BCA_IDLE;
                    next_st.done = 1'b1;
                end
                default: begin
                    next_st.seg = bca_pkg::BCA_IDLE;
                end
            endcase
            if (ok) begin
                next_st.shreg      = unit;
                next_st.bits_left  = `BCA_UNIT_BITS;
                next_st.div        = '0;
                next_st.phase      = 1'b0;
                next_st.chan_bit   = unit[15];
                next_st.stripe     = unit[15];
                next_st.bit_strobe = 1'b1;
            end else if (st.seg == bca_pkg::BCA_ROWS) begin
                // starved source: line stays dark, frame is flawed
                next_st.underrun = 1'b1;
            end
        end else begin
            next_st.div = st.div + 9'd1;
            if (st.div == `BCA_HALF_CYC - 9'd1) begin
                next_st.div = '0;
                if (!st.phase) begin
                    next_st.phase  = 1'b1;
                    next_st.stripe = 1'b0;
                end else begin
                    next_st.phase     = 1'b0;
                    next_st.bits_left = st.bits_left - 5'd1;
                    next_st.shreg     = {st.shreg[14:0], 1'b0};
                    if (st.bits_left != 5'd1) begin
                        next_st.chan_bit   = st.shreg[14];
                        next_st.stripe     = st.shreg[14];
                        next_st.bit_strobe = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st     <= '0;
            st.seg <= bca_pkg::BCA_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign stripe     = st.stripe;
    assign chan_bit   = st.chan_bit;
    assign bit_strobe = st.bit_strobe;
    assign busy       = (st.seg != bca_pkg::BCA_IDLE);
    assign done       = st.done;
    assign underrun   = st.underrun;
endmodule // bca_encoder
`default_nettype wire

// ==== design/bca_dummy_never.sv ====
// intentionally empty file
`default_nettype none
`default_nettype wire

// ==== testbench/bca_encoder_monitor.sv ====
// port checker for the burst area encoder
`default_nettype none
module bca_encoder_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       start,
    input wire logic [3:0] n_rows,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire logic [7:0] in_data,
    input wire logic       stripe,
    input wire logic       chan_bit,
    input wire logic       bit_strobe,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       underrun
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 32;
    int hi_run;
    int gap;
    // run length of stripe and distance between strobes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hi_run <= 0;
            gap    <= 0;
        end else begin
            hi_run <= stripe ? hi_run + 1 : 0;
            gap    <= bit_strobe ? 1 : gap + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_first;
        start && !busy && n_rows >= 1 && n_rows <= 12 |=>
            busy ##1 (bit_strobe && !chan_bit && !stripe);
    endproperty
    a_first: assert property (p_first) else $error("frame does not open with marker bit");
    property p_refuse;
        start && !busy && (n_rows == 0 || n_rows > 12) |=> !busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad row count accepted");
    property p_rz;
        stripe |-> chan_bit;
    endproperty
    a_rz: assert property (p_rz) else $error("stripe on a zero channel bit");
    property p_rise;
        $rose(stripe) |-> bit_strobe;
    endproperty
    a_rise: assert property (p_rise) else $error("stripe starts mid bit");
    property p_half;
        hi_run <= HALF;
    endproperty
    a_half: assert property (p_half) else $error("stripe longer than half a bit");
    property p_gap;
        bit_strobe && !underrun && $past(busy, 3) |-> gap == 64 || gap == 65;
    endproperty
    a_gap: assert property (p_gap) else $error("gap in channel bit train");
    property p_done;
        done |-> !busy && $past(busy) ##1 !done;
    endproperty
    a_done: assert property (p_done) else $error("done not a single end pulse");
    property p_hold;
        busy && !bit_strobe && !underrun && $past(busy) |-> $stable(chan_bit);
    endproperty
    a_hold: assert property (p_hold) else $error("channel bit changed off strobe");
endmodule // bca_encoder_monitor
bind bca_encoder bca_encoder_monitor mon (.clk_sys(clk_sys), .rst(rst), .start(start),
    .n_rows(n_rows), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .stripe(stripe), .chan_bit(chan_bit), .bit_strobe(bit_strobe), .busy(busy),
    .done(done), .underrun(underrun));
`default_nettype wire

// ==== testbench/bca_reader.sv ====
// stripe reader model at the channel side of the encoder
`default_nettype none
module bca_reader (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stripe,
    input wire logic chan_bit,
    input wire logic bit_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bits[$];
    int   pulses;
    logic last;
    // reads registered outputs before this edge's updates land
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bits.delete();
            pulses = 0;
            last = 1'b0;
        end else begin
            if (bit_strobe) bits.push_back(chan_bit);
            if (stripe && !last) pulses++;
            last = stripe;
        end
    end
endmodule // bca_reader
`default_nettype wire

// ==== testbench/bca_encoder_tb.sv ====
// self-checking bench for the burst area encoder
`default_nettype none
module bca_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       start = 1'b0;
    logic [3:0] n_rows = 4'h1;
    logic       in_valid = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic       in_ready, stripe, chan_bit, bit_strobe, busy, done, underrun;
    int         failures = 0;
    int         samples_checked = 0;
    logic [7:0] info[$];
    logic [7:0] dat[$];
    logic       exp_q[$];

    always #4 clk_sys = ~clk_sys;

    bca_encoder dut (.clk_sys(clk_sys), .rst(rst), .start(start), .n_rows(n_rows),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .stripe(stripe),
        .chan_bit(chan_bit), .bit_strobe(bit_strobe), .busy(busy), .done(done),
        .underrun(underrun));
    bca_reader rd (.clk_sys(clk_sys), .rst(rst), .stripe(stripe), .chan_bit(chan_bit),
        .bit_strobe(bit_strobe));

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, e, g);
        end
    endtask

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
        end
        return p;
    endfunction

    task automatic put_byte(input logic [7:0] b, input logic inv);
        for (int i = 7; i >= 0; i--) begin
            exp_q.push_back(b[i] ^ inv);
            exp_q.push_back(~b[i] ^ inv);
        end
    endtask

    task automatic put_mark(input logic [3:0] code);
        logic [7:0] m;
        m = 8'h46;
        for (int i = 7; i >= 0; i--) exp_q.push_back(m[i]);
        put_byte({code, 4'h0}, 1'b1);
        repeat (8) void'(exp_q.pop_back());
    endtask

    // reference frame from the info bytes
    task automatic build(input int n);
        logic [31:0] crc;
        logic [7:0]  g[0:4];
        logic [7:0]  r[0:3];
        logic [7:0]  par[0:3][0:3];
        logic [7:0]  ak;
        logic [7:0]  fb;
        crc = 32'h00000000;
        foreach (info[k]) for (int i = 7; i >= 0; i--) begin
            fb[0] = crc[31] ^ info[k][i];
            crc = {crc[30:0], 1'b0} ^ (fb[0] ? 32'h80000011 : 32'h00000000);
        end
        g = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        ak = 8'h01;
        for (int k = 0; k < 4; k++) begin
            for (int m = 4; m > 0; m--) g[m] = g[m-1] ^ gmul(ak, g[m]);
            g[0] = gmul(ak, g[0]);
            ak = gmul(ak, 8'h02);
        end
        dat = info;
        for (int i = 3; i >= 0; i--) dat.push_back(crc[8*i +: 8]);
        for (int j = 0; j < 4; j++) begin
            r = '{default: 8'h00};
            for (int k = j; k < 16*n; k += 4) begin
                fb = dat[k] ^ r[0];
                for (int i = 0; i < 3; i++) r[i] = r[i+1] ^ gmul(fb, g[3-i]);
                r[3] = gmul(fb, g[0]);
            end
            for (int i = 0; i < 4; i++) par[i][j] = r[i];
        end
        for (int i = 0; i < 16; i++) dat.push_back(par[i/4][i%4]);
        exp_q.delete();
        put_mark(4'h0);
        repeat (4) put_byte(8'h00, 1'b1);
        for (int w = 0; w < 4*n+4; w++) begin
            put_mark(w < 4*n ? 4'(w/4 + 1) : 4'hD);
            for (int b = 0; b < 4; b++) put_byte(dat[4*w+b], 1'b0);
        end
        put_mark(4'hE);
        repeat (4) put_byte(8'h55, 1'b1);
        put_mark(4'hF);
    endtask

    // called at a falling edge; returns after the byte is taken
    task automatic push(input logic [7:0] b);
        in_valid = 1'b1;
        in_data = b;
        while (in_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one n=1 frame is about 52k cycles, the stall test about 6k
    initial begin
        repeat (90000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end

    initial begin
        int k;
        int ones;
        void'($urandom(32'h12f61d2e));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk("in_ready", 1, in_ready);
        for (int i = 0; i < 2; i++) begin
            n_rows = i ? 4'hD : 4'h0;
            start = 1'b1;
            @(negedge clk_sys);
            start = 1'b0;
            @(negedge clk_sys);
            chk("busy_refused", 0, busy);
        end
        // source starves after the first resync marker: frame stalls dark
        n_rows = 4'h1;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        repeat (6300) @(negedge clk_sys);
        exp_q.delete();
        put_mark(4'h0);
        repeat (4) put_byte(8'h00, 1'b1);
        put_mark(4'h1);
        chk("stall_bits", 32'(exp_q.size()), 32'(rd.bits.size()));
        foreach (exp_q[i]) chk("stall_bit", exp_q[i], rd.bits[i]);
        chk("underrun_set", 1, underrun);
        chk("stall_stripe", 0, stripe);
        chk("busy_stall", 1, busy);
        // reset in mid-frame must drop the frame and the flag
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk("busy_reset", 0, busy);
        chk("underrun_reset", 0, underrun);
        chk("chan_bit_reset", 0, chan_bit);
        @(negedge clk_sys);
        chk("busy_after_reset", 0, busy);
        chk("in_ready_reset", 1, in_ready);
        for (int i = 0; i < 12; i++) info.push_back(8'($urandom));
        for (int i = 0; i < 8; i++) push(info[i]);
        in_data = info[8];
        repeat (3) @(negedge clk_sys);
        chk("in_ready_full", 0, in_ready);
        n_rows = 4'h1;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        for (int i = 8; i < 12; i++) push(info[i]);
        in_valid = 1'b0;
        // a start mid-frame must not restart or resize the frame
        n_rows = 4'h3;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        build(1);
        k = 0;
        while (done !== 1'b1 && k < 60000) begin
            @(negedge clk_sys);
            k++;
        end
        chk("done", 1, done);
        chk("bit_count", 32'(exp_q.size()), 32'(rd.bits.size()));
        for (int i = 0; i < exp_q.size() && failures < 8; i++) begin
            chk("chan_bit", exp_q[i], rd.bits[i]);
        end
        ones = 0;
        foreach (exp_q[i]) ones += exp_q[i];
        chk("stripe_pulses", 32'(ones), 32'(rd.pulses));
        chk("underrun", 0, underrun);
        @(negedge clk_sys);
        chk("busy_end", 0, busy);
        wrap_up();
    end
endmodule // bca_encoder_tb
`default_nettype wire
